// ---- verilog/gsbt_timer.sv ----
// Gated sixteen-bit timer with prescaler, overflow flag and AXI4-Lite registers.
// Overview of operation
// - 16-bit count wraps, sets overflow flag
// - Interrupt needs three enables all set
// - Overflow flag stays until software clears
// - Internal source counts every instruction cycle
// - External source counts pin rising edges
// - Falling edge needed before first count
// - Gate enable counts only while gate low
// - Prescale field divides by 1,2,4,8
// - Counter byte write clears hidden prescaler
// - Sync disable picks synchronised or raw path
// - Asynchronous mode keeps counting in sleep
// - Sleep counting and wake conditions
// - Wake with global enable vectors
// - Byte reads always return valid value
// - Crystal enable only with internal oscillator
// - Crystal forces pin directions to input
// - Control bit zero runs or halts
// - Control clears on power-on reset only, top bit zero
// - Counter bytes untouched by reset
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps

module gsbt_timer #(
  parameter int INSTR_DIV = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_event,
  input  wire logic        sleep_mode,
  input  wire logic        internal_oscillator,
  input  wire logic        ext_count_clock_pin,
  input  wire logic        crystal_out_pin,
  input  wire logic        gate_pin_n,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             wake,
  output logic             pin_four_direction,
  output logic             pin_five_direction
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0]  count_low_byte_reg;
  logic [7:0]  count_high_byte_reg;
  logic [7:0]  control_reg;
  logic [7:0]  intctl_reg;
  logic [7:0]  enables_reg;
  logic        flag_reg;
  logic [2:0]  presc_reg;
  logic [1:0]  instr_cnt_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [9:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_ok;
  logic        w_ok;
  logic        do_write;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_byte;
  logic [7:0]  wr_val;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [7:0]  rd_val;

  // Decoded control fields.
  logic        counter_on;
  logic        gate_enable;
  logic [1:0]  prescale_select;
  logic        lp_osc_enable;
  logic        sync_disable;
  logic        clock_source_select;
  logic        lp_active;
  logic        ext_src;
  logic        ext_rise;
  logic        instr_tick;
  logic        gate_open;
  logic        src_tick;
  logic        presc_done;
  logic        inc;
  logic [15:0] count_sum;
  logic        wrap;
  logic        wr_low;
  logic        wr_high;
  logic        wr_flags;
  logic        async_mode;

  assign counter_on          = control_reg[gsbt_pkg::BIT_COUNTER_ON];
  assign gate_enable         = control_reg[gsbt_pkg::BIT_GATE_ENABLE];
  assign prescale_select     = control_reg[gsbt_pkg::BIT_PRESCALE_HI:gsbt_pkg::BIT_PRESCALE_LO];
  assign lp_osc_enable       = control_reg[gsbt_pkg::BIT_LP_OSC_ENABLE];
  assign sync_disable        = control_reg[gsbt_pkg::BIT_SYNC_DISABLE];
  assign clock_source_select = control_reg[gsbt_pkg::BIT_CLOCK_SOURCE_SELECT];

  // ==========================================================================
  // Clock source selection
  // ==========================================================================
  // The crystal only stands in for the pin when the internal oscillator runs the core.
  assign lp_active  = lp_osc_enable && internal_oscillator;
  assign ext_src    = clock_source_select;
  assign async_mode = ext_src && sync_disable;

  gsbt_edge_detect u_edge (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ext_in       (lp_active ? crystal_out_pin : ext_count_clock_pin),
    .sync_disable (sync_disable),
    .enable       (counter_on && ext_src),
    .rise_pulse   (ext_rise)
  );

  // Instruction cycle enable: one pulse every INSTR_DIV clocks.
  assign instr_tick = (instr_cnt_reg == 2'(INSTR_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_cnt_reg <= 2'h0;
    end else begin
      instr_cnt_reg <= instr_tick ? 2'h0 : instr_cnt_reg + 2'h1;
    end
  end

  // Gate is ignored unless the counter is on; gate enable then needs the gate pin low.
  assign gate_open = counter_on && (!gate_enable || !gate_pin_n);
  // Internal source is halted in sleep; only asynchronous external counting runs there.
  assign src_tick  = ext_src ? (ext_rise && (!sleep_mode || async_mode))
                             : (instr_tick && !sleep_mode);

  // ==========================================================================
  // Prescaler and counter
  // ==========================================================================
  always_comb begin
    case (prescale_select)
      2'h0:    presc_done = 1'b1;
      2'h1:    presc_done = presc_reg[0];
      2'h2:    presc_done = &presc_reg[1:0];
      2'h3:    presc_done = &presc_reg;
      default: presc_done = 1'b1;
    endcase
  end

  assign inc       = gate_open && src_tick && presc_done;
  assign count_sum = {count_high_byte_reg, count_low_byte_reg} + 16'h0001;
  assign wrap      = inc && (count_sum == 16'h0000);

  // Write path decode.
  assign aw_ok     = aw_hold_reg || s_axi_awvalid;
  assign w_ok      = w_hold_reg || s_axi_wvalid;
  assign do_write  = aw_ok && w_ok && !s_axi_bvalid;
  assign wr_idx    = aw_hold_reg ? awaddr_reg[9:2] : s_axi_awaddr[9:2];
  assign wr_byte   = w_hold_reg ? wstrb_reg[0] : s_axi_wstrb[0];
  assign wr_val    = w_hold_reg ? wdata_reg[7:0] : s_axi_wdata[7:0];
  assign wr_low    = do_write && wr_byte && (wr_idx == gsbt_pkg::IDX_COUNT_LOW_BYTE);
  assign wr_high   = do_write && wr_byte && (wr_idx == gsbt_pkg::IDX_COUNT_HIGH_BYTE);
  assign wr_flags  = do_write && wr_byte && (wr_idx == gsbt_pkg::IDX_PERIPHERAL_FLAGS);
  assign wr_mapped = (wr_idx == gsbt_pkg::IDX_INTERRUPT_CONTROL)
                  || (wr_idx == gsbt_pkg::IDX_PERIPHERAL_FLAGS)
                  || (wr_idx == gsbt_pkg::IDX_COUNT_LOW_BYTE)
                  || (wr_idx == gsbt_pkg::IDX_COUNT_HIGH_BYTE)
                  || (wr_idx == gsbt_pkg::IDX_COUNTER_CONTROL)
                  || (wr_idx == gsbt_pkg::IDX_PERIPHERAL_ENABLES);

  // Prescaler is hidden from software; any counter byte write restarts it.
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_low || wr_high) begin
      presc_reg <= 3'h0;
    end else if (gate_open && src_tick) begin
      presc_reg <= presc_done ? 3'h0 : presc_reg + 3'h1;
    end
  end

  // Counter bytes carry no reset: their content survives every reset.
  // A write beats a same-cycle increment; stop the timer first.
  always_ff @(posedge aclk) begin
    if (wr_low) begin
      count_low_byte_reg <= wr_val;
    end else if (inc) begin
      count_low_byte_reg <= count_sum[7:0];
    end
    if (wr_high) begin
      count_high_byte_reg <= wr_val;
    end else if (inc) begin
      count_high_byte_reg <= count_sum[15:8];
    end
  end

  // Overflow flag: a wrap in the same cycle as a software clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (wrap) begin
      flag_reg <= 1'b1;
    end else if (wr_flags) begin
      flag_reg <= wr_val[gsbt_pkg::BIT_OVERFLOW_FLAG];
    end
  end

  // Control keeps its bits on a plain reset; only power-on clears them.
  always_ff @(posedge aclk) begin
    if (!aresetn && por_event) begin
      control_reg <= gsbt_pkg::CONTROL_RESET;
      intctl_reg  <= gsbt_pkg::INTCTL_RESET;
      enables_reg <= gsbt_pkg::ENABLES_RESET;
    end else if (!aresetn) begin
      intctl_reg  <= gsbt_pkg::INTCTL_RESET;
      enables_reg <= gsbt_pkg::ENABLES_RESET;
    end else if (do_write && wr_byte) begin
      if (wr_idx == gsbt_pkg::IDX_COUNTER_CONTROL) begin
        control_reg <= wr_val & gsbt_pkg::CONTROL_WMASK;
      end
      if (wr_idx == gsbt_pkg::IDX_INTERRUPT_CONTROL) begin
        intctl_reg <= wr_val;
      end
      if (wr_idx == gsbt_pkg::IDX_PERIPHERAL_ENABLES) begin
        enables_reg <= wr_val & 8'h01;
      end
    end
  end

  // ==========================================================================
  // Interrupt, wake and pin outputs
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq                <= 1'b0;
      wake               <= 1'b0;
      pin_four_direction <= 1'b0;
      pin_five_direction <= 1'b0;
    end else begin
      irq  <= flag_reg && enables_reg[gsbt_pkg::BIT_OVERFLOW_IRQ_ENABLE]
           && intctl_reg[gsbt_pkg::BIT_PERIPHERAL_IRQ_ENABLE]
           && intctl_reg[gsbt_pkg::BIT_GLOBAL_IRQ_ENABLE]
           && (!sleep_mode || counter_on);
      wake <= sleep_mode && flag_reg && counter_on
           && enables_reg[gsbt_pkg::BIT_OVERFLOW_IRQ_ENABLE]
           && intctl_reg[gsbt_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
      pin_four_direction <= lp_active;
      pin_five_direction <= lp_active;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  // Address and data may arrive in either order; each is held until its partner comes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= 10'h000;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gsbt_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg   <= 1'b0;
        w_hold_reg    <= 1'b0;
        s_axi_awready <= !aw_hold_reg;
        s_axi_wready  <= !w_hold_reg;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_mapped ? gsbt_pkg::RESP_OKAY : gsbt_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && !aw_hold_reg && !s_axi_awready) begin
          aw_hold_reg   <= 1'b1;
          awaddr_reg    <= s_axi_awaddr;
          s_axi_awready <= 1'b1;
        end
        if (s_axi_wvalid && !w_hold_reg && !s_axi_wready) begin
          w_hold_reg   <= 1'b1;
          wdata_reg    <= s_axi_wdata;
          wstrb_reg    <= s_axi_wstrb;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  // Reads come from registered bytes, so each byte is whole.
  assign rd_idx = s_axi_araddr[9:2];

  always_comb begin
    rd_mapped = 1'b1;
    case (rd_idx)
      gsbt_pkg::IDX_INTERRUPT_CONTROL:  rd_val = intctl_reg;
      gsbt_pkg::IDX_PERIPHERAL_FLAGS:   rd_val = {7'h00, flag_reg};
      gsbt_pkg::IDX_COUNT_LOW_BYTE:     rd_val = count_low_byte_reg;
      gsbt_pkg::IDX_COUNT_HIGH_BYTE:    rd_val = count_high_byte_reg;
      gsbt_pkg::IDX_COUNTER_CONTROL:    rd_val = control_reg;
      gsbt_pkg::IDX_PERIPHERAL_ENABLES: rd_val = enables_reg;
      gsbt_pkg::IDX_SYSTEM_STATUS:      rd_val = {6'h00, lp_active, lp_active};
      default: begin
        rd_val    = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gsbt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_val};
        s_axi_rresp   <= rd_mapped ? gsbt_pkg::RESP_OKAY : gsbt_pkg::RESP_SLVERR;
      end
    end
  end

endmodule : gsbt_timer

// ---- verilog/gsbt_pkg.sv ----
// Package with register map, field positions, reset values and shared types of the timer.
package gsbt_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Some printed offsets are not word multiples, so each is an index (byte address = 4 x index).
  localparam logic [7:0] IDX_INTERRUPT_CONTROL  = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_COUNT_LOW_BYTE     = 8'h0E;
  localparam logic [7:0] IDX_COUNT_HIGH_BYTE    = 8'h0F;
  localparam logic [7:0] IDX_COUNTER_CONTROL    = 8'h10;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_SYSTEM_STATUS      = 8'h40;
  localparam int         ADDR_W                 = 10;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int BIT_GLOBAL_IRQ_ENABLE     = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BIT_OVERFLOW_FLAG         = 0;
  localparam int BIT_OVERFLOW_IRQ_ENABLE   = 0;
  localparam int BIT_GATE_ENABLE           = 6;
  localparam int BIT_PRESCALE_HI           = 5;
  localparam int BIT_PRESCALE_LO           = 4;
  localparam int BIT_LP_OSC_ENABLE         = 3;
  localparam int BIT_SYNC_DISABLE          = 2;
  localparam int BIT_CLOCK_SOURCE_SELECT   = 1;
  localparam int BIT_COUNTER_ON            = 0;

  // Writable masks and reset values.
  localparam logic [7:0] CONTROL_WMASK     = 8'h7F;
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] INTCTL_RESET      = 8'h00;
  localparam logic [7:0] ENABLES_RESET     = 8'h00;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    GSBT_FE_IDLE,
    GSBT_FE_ARMED
  } gsbt_arm_t;

  typedef struct packed {
    logic       ext_level;
    logic       sync_a;
    logic       sync_b;
    logic       sync_prev;
    gsbt_arm_t  arm;
  } gsbt_edge_t;

endpackage : gsbt_pkg

// ---- verilog/gsbt_edge_detect.sv ----
// Rising edge detector of the external count clock with falling edge arming.
`timescale 1ns/10ps

module gsbt_edge_detect (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_in,
  input  wire logic sync_disable,
  input  wire logic enable,
  output logic      rise_pulse
);

  gsbt_pkg::gsbt_edge_t st_reg;
  gsbt_pkg::gsbt_edge_t st_next;
  logic                 cur;
  logic                 prev;

  // ==========================================================================
  // Edge logic
  // ==========================================================================
  // Sync path has two flops; the raw path one, a cycle faster.
  always_comb begin
    st_next           = st_reg;
    st_next.ext_level = ext_in;
    st_next.sync_a    = ext_in;
    st_next.sync_b    = st_reg.sync_a;
    cur               = sync_disable ? st_reg.ext_level : st_reg.sync_b;
    prev              = st_reg.sync_prev;
    st_next.sync_prev = cur;
    rise_pulse        = 1'b0;
    if (!enable) begin
      st_next.arm = gsbt_pkg::GSBT_FE_IDLE;
    end else begin
      case (st_reg.arm)
        gsbt_pkg::GSBT_FE_IDLE: begin
          if (prev && !cur) begin
            st_next.arm = gsbt_pkg::GSBT_FE_ARMED;
          end
        end
        gsbt_pkg::GSBT_FE_ARMED: begin
          rise_pulse = !prev && cur;
        end
        default: st_next.arm = gsbt_pkg::GSBT_FE_IDLE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{1'b0, 1'b0, 1'b0, 1'b0, gsbt_pkg::GSBT_FE_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : gsbt_edge_detect

// ---- verif/gsbt_pin_model.sv ----
// Model of the pins beyond the timer: external count clock, crystal and gate.
`timescale 1ns/10ps

module gsbt_pin_model (
  input  wire logic aclk,
  output logic      ext_count_clock_pin,
  output logic      crystal_out_pin,
  output logic      gate_pin_n
);
  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Clock lines rest low, so a burst's first rise is not counted.
  initial begin
    {ext_count_clock_pin, crystal_out_pin, gate_pin_n} = 3'b001;
  end

  // Burst of n periods; each half lasts half clock cycles.
  task automatic burst(input int n, input int half);
    repeat (2 * n) begin
      repeat (half) @(posedge aclk);
      {ext_count_clock_pin, crystal_out_pin} <= ~{ext_count_clock_pin, crystal_out_pin};
    end
  endtask : burst

  // Gate is active low.
  task automatic gate(input logic level);
    gate_pin_n <= level;
  endtask : gate
endmodule : gsbt_pin_model

// ---- verif/gsbt_properties.sv ----
// Concurrent checks on the timer's bus handshake and event outputs.
`timescale 1ns/10ps

module gsbt_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        sleep_mode,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq,
  input wire logic        wake,
  input wire logic        pin_four_direction,
  input wire logic        pin_five_direction
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence s_rd_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> s_axi_bvalid)
    else $error("write without response");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read without data");
  a_rdata_holds: assert property (s_rd_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");

  // ==========================================================================
  // Events and pins
  // ==========================================================================
  // Apart from entering sleep with the counter off, only a register write can make irq fall.
  a_irq_sticky: assert property ($fell(irq) |->
    $past(s_axi_wready) || $past(s_axi_wready, 2) || $past(s_axi_wready, 3))
    else $error("irq fell without a write");
  a_wake_sleep: assert property (wake |-> $past(sleep_mode))
    else $error("wake raised outside sleep");
  a_dirs_paired: assert property (pin_four_direction == pin_five_direction)
    else $error("crystal pin directions differ");
  a_reset_quiet: assert property (!$past(aresetn) |-> !irq && !wake && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule : gsbt_properties

bind gsbt_timer gsbt_properties i_gsbt_properties (.aclk, .aresetn, .sleep_mode,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq, .wake, .pin_four_direction,
  .pin_five_direction);

// ---- verif/gsbt_timer_bench.sv ----
// Self-checking testbench of the gated sixteen-bit timer.
`timescale 1ns/10ps

module gsbt_timer_bench;
  localparam logic [7:0] CTL = gsbt_pkg::IDX_COUNTER_CONTROL;
  localparam logic [7:0] LO  = gsbt_pkg::IDX_COUNT_LOW_BYTE;
  localparam logic [7:0] HI  = gsbt_pkg::IDX_COUNT_HIGH_BYTE;
  localparam logic [7:0] FLG = gsbt_pkg::IDX_PERIPHERAL_FLAGS;
  localparam logic [7:0] ENA = gsbt_pkg::IDX_PERIPHERAL_ENABLES;
  localparam logic [7:0] ICT = gsbt_pkg::IDX_INTERRUPT_CONTROL;
  logic        aclk, aresetn, por_event, sleep_mode, internal_oscillator;
  logic        ext_count_clock_pin, crystal_out_pin, gate_pin_n, irq, wake;
  logic        pin_four_direction, pin_five_direction;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  d, lo_b, hi_b;
  logic [7:0]  regs [4];
  int          failures, compares;

  // ==========================================================================
  // Clock, design and pins
  // ==========================================================================
  // Free-running 125 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  gsbt_timer #(.INSTR_DIV(4)) i_gsbt_timer (.aclk, .aresetn, .por_event, .sleep_mode,
    .internal_oscillator, .ext_count_clock_pin, .crystal_out_pin, .gate_pin_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .wake, .pin_four_direction, .pin_five_direction);
  gsbt_pin_model i_gsbt_pin_model (.aclk, .ext_count_clock_pin, .crystal_out_pin, .gate_pin_n);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // First rise after enabling is not counted.
  function automatic logic [15:0] expect_count(input logic [15:0] s, input int n, input int ps);
    return s + 16'((n - 1) >> ps);
  endfunction : expect_count

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("FAIL %0t count %h out of range", $time, got);
    end
  endtask : chk_rng

  // Requests stand until the rising edge that samples their ready high.
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      resp = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      {v, resp} = {s_axi_rdata[7:0], s_axi_rresp};
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic reset(input logic por);
    @(posedge aclk);
    {aresetn, por_event} <= {1'b0, por};
    repeat (3) @(posedge aclk);
    {aresetn, por_event} <= 2'b10;
  endtask : reset

  task automatic chk_count(input logic [15:0] exp);
    rd(LO, lo_b);
    rd(HI, hi_b);
    chk8(lo_b, exp[7:0]);
    chk8(hi_b, exp[15:8]);
  endtask : chk_count

  // Stop, load, start, then clock the pin.
  task automatic ext_run(input logic [7:0] ctl, input int n, input logic [15:0] s);
    wr(CTL, 8'h00);
    wr(LO, s[7:0]);
    wr(HI, s[15:8]);
    wr(CTL, ctl);
    i_gsbt_pin_model.burst(n, ctl[2] ? 4 : 3);
    repeat (6) @(posedge aclk);
  endtask : ext_run

  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Main sequence.
  initial begin
    {aresetn, por_event, sleep_mode, internal_oscillator} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_wstrb = 4'hF;
    {failures, compares} = 0;
    seed = 32'hD1CA10A6;
    regs = '{ICT, FLG, CTL, ENA};
    reset(1'b1);
    foreach (regs[i]) begin
      rd(regs[i], d);
      chk8(d, 8'h00);
    end
    wr(CTL, 8'hFF);
    rd(CTL, d);
    chk8(d, 8'h7F);
    wr(8'h20, 8'h55);
    chk8({6'h00, resp}, {6'h00, gsbt_pkg::RESP_SLVERR});
    rd(8'h20, d);
    chk8({d[5:0], resp}, {6'h00, gsbt_pkg::RESP_SLVERR});
    wr(CTL, 8'h00);
    repeat (4) begin
      seed = xs(seed);
      wr(LO, seed[7:0]);
      wr(HI, seed[15:8]);
      chk_count(seed[15:0]);
    end
    for (int ps = 0; ps < 4; ps++) begin
      for (int sd = 0; sd < 2; sd++) begin
        seed = xs(seed);
        ext_run({2'b00, 2'(ps), 1'b0, 1'(sd), 2'b11}, 9 + int'(seed[18:16]), seed[15:0]);
        chk_count(expect_count(seed[15:0], 9 + int'(seed[18:16]), ps));
      end
    end
    ext_run(8'h43, 8, 16'h0100);
    chk_count(16'h0100);
    i_gsbt_pin_model.gate(1'b0);
    ext_run(8'h43, 8, 16'h0100);
    chk_count(16'h0107);
    i_gsbt_pin_model.gate(1'b1);
    for (int k = 0; k < 2; k++) begin
      ext_run({5'h00, k[0], 2'b01}, 0, 16'h0000);
      repeat (400) @(posedge aclk);
      wr(CTL, 8'h00);
      rd(LO, lo_b);
      rd(HI, hi_b);
      chk_rng({hi_b, lo_b}, 100, 105);
      repeat (40) @(posedge aclk);
      chk_count({hi_b, lo_b});
    end
    wr(FLG, 8'h00);
    ext_run(8'h03, 4, 16'hFFFD);
    chk_count(16'h0000);
    for (int c = 0; c < 8; c++) begin
      wr(ENA, {7'h00, c[0]});
      wr(ICT, {c[2:1], 6'h00});
      repeat (3) @(posedge aclk);
      chk8({7'h00, irq}, {7'h00, &c[2:0]});
    end
    rd(FLG, d);
    chk8(d, 8'h01);
    wr(FLG, 8'h00);
    rd(FLG, d);
    chk8({d[6:0], irq}, 8'h00);
    sleep_mode <= 1'b1;
    wr(ICT, 8'h40);
    ext_run(8'h07, 4, 16'hFFFD);
    chk8({6'h00, wake, irq}, 8'h02);
    wr(ICT, 8'hC0);
    repeat (3) @(posedge aclk);
    chk8({6'h00, wake, irq}, 8'h03);
    wr(FLG, 8'h00);
    ext_run(8'h03, 6, 16'h0000);
    chk_count(16'h0000);
    sleep_mode <= 1'b0;
    wr(CTL, 8'h08);
    for (int k = 0; k < 2; k++) begin
      internal_oscillator <= k[0];
      repeat (3) @(posedge aclk);
      rd(gsbt_pkg::IDX_SYSTEM_STATUS, d);
      chk8(d, {6'h00, {2{k[0]}}});
      chk8({6'h00, pin_five_direction, pin_four_direction}, {6'h00, {2{k[0]}}});
    end
    wr(CTL, 8'h30);
    wr(LO, 8'hA5);
    wr(HI, 8'h5A);
    reset(1'b0);
    rd(CTL, d);
    chk8(d, 8'h30);
    chk_count(16'h5AA5);
    conclude();
  end

  // Watchdog.
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude();
  end
endmodule : gsbt_timer_bench
